// File: src/cms_top.sv
// Device-level compatibility, sleep, port and register-file control.
// Assumes one clock, a synchronous reset held at least three edges,
// and an AXI4-Lite master that keeps one write and one read open.
//
// Functional notes
// - Extra I/O registers sit at data 0x60-0xFF, unreachable by I/O ops.
// - Short I/O space keeps its 64 predecessor locations unchanged.
// - Fuse programmed: whole extended window decodes as plain RAM.
// - Fuse programmed: extended interrupt vectors are dropped.
// - Fuse programmed: watchdog timeout change needs no timed sequence.
// - Fuse programmed: serial receivers use a single receive buffer.
// - Fuse programmed: no pin-change interrupts.
// - Fuse programmed: only the first wide timer is usable.
// - Two baud high registers, addresses fixed regardless of fuse.
// - Every port pin is tri-stated while reset is active.
// - Per-pin pull-up; it only acts while selected.
// - Idle halts CPU; SRAM, timers, SPI and interrupts keep running.
// - Power-down stops oscillator until interrupt or reset.
// - Power-save keeps the asynchronous timer counting.
// - Standby keeps the main oscillator running only.
// - Extended standby keeps main oscillator and asynchronous timer.
// - Boot code keeps executing while application memory is written.
// - Register file gives two reads and a write in one cycle.
`timescale 1ns/10ps
`default_nettype none
`include "cms_defs.svh"

module cms_top
    import cms_pkg::*;
#(
    parameter int PW = 8,                     // port width
    parameter int BW = 8                      // baud high width
) (
    input  wire logic          mclk_i,        // system clock
    input  wire logic          srst_i,        // sync reset, high
    input  wire logic          fuse_i,        // compat fuse pin
    input  wire logic [15:0]   daddr_i,       // data address
    input  wire logic [5:0]    ioaddr_i,      // short I/O address
    input  wire logic          wake_i,        // interrupt wake
    input  wire logic          boot_fetch_i,  // fetch from boot
    input  wire logic          app_wr_i,      // app memory busy
    input  wire logic [4:0]    rf_ra_i,       // read port a
    input  wire logic [4:0]    rf_rb_i,       // read port b
    input  wire logic          rf_we_i,       // write enable
    input  wire logic [4:0]    rf_wa_i,       // write address
    input  wire logic [7:0]    rf_wd_i,       // write data
    input  wire logic [PW-1:0] pin_i,         // pin level
    output logic [PW-1:0]      pin_o,         // pin drive
    output logic [PW-1:0]      pin_oe_n_o,    // drive enable, low
    output logic [PW-1:0]      pullup_o,      // pull-up on
    output cms_sel_t           dsel_o,        // data decode
    output cms_sel_t           iosel_o,       // I/O decode
    output logic               xvec_o,        // extended vectors
    output logic               wdt_seq_o,     // timed seq needed
    output logic               rx_dbl_o,      // double rx buffer
    output logic               pcint_en_o,    // pin-change irq on
    output logic               tmr2_en_o,     // second wide timer
    output logic [BW-1:0]      baud0_o,       // port0_baud_high
    output logic [BW-1:0]      baud1_o,       // port1_baud_high
    output logic               cpu_run_o,     // CPU clock on
    output logic               io_run_o,      // peripherals on
    output logic               osc_run_o,     // main oscillator on
    output logic               atmr_run_o,    // async timer on
    output logic               stall_o,       // CPU fetch stall
    output logic [7:0]         rf_a_o,        // read data a
    output logic [7:0]         rf_b_o,        // read data b
    input  wire logic [31:0]   s_axi_awaddr,  // write address
    input  wire logic          s_axi_awvalid, // aw valid
    output logic               s_axi_awready, // aw ready
    input  wire logic [31:0]   s_axi_wdata,   // write data
    input  wire logic [3:0]    s_axi_wstrb,   // byte strobes
    input  wire logic          s_axi_wvalid,  // w valid
    output logic               s_axi_wready,  // w ready
    output logic [1:0]         s_axi_bresp,   // write response
    output logic               s_axi_bvalid,  // b valid
    input  wire logic          s_axi_bready,  // b ready
    input  wire logic [31:0]   s_axi_araddr,  // read address
    input  wire logic          s_axi_arvalid, // ar valid
    output logic               s_axi_arready, // ar ready
    output logic [31:0]        s_axi_rdata,   // read data
    output logic [1:0]         s_axi_rresp,   // read response
    output logic               s_axi_rvalid,  // r valid
    input  wire logic          s_axi_rready   // r ready
);

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    function automatic cms_sel_t decode(
        input logic [15:0] a,
        input logic        legacy
    );
        cms_sel_t s;
        s = CMS_SEL_RAM;
        if (a < `CMS_IO_BASE)
            s = CMS_SEL_REGF;
        else if (a < `CMS_EXT_LO)
            s = CMS_SEL_IO;
        else if (a <= `CMS_EXT_HI)
            s = legacy ? CMS_SEL_RAM
                       : CMS_SEL_EXT;
        return s;
    endfunction

    function automatic cms_sleep_t mode_of(input logic [2:0] c);
        cms_sleep_t m;
        case (c)
            `CMS_MD_PDOWN: m = CMS_SM_PDOWN;
            `CMS_MD_PSAVE: m = CMS_SM_PSAVE;
            `CMS_MD_STBY:  m = CMS_SM_STBY;
            `CMS_MD_XSTBY: m = CMS_SM_XSTBY;
            default:       m = CMS_SM_IDLE;
        endcase
        return m;
    endfunction

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic          fuse_s1_q;
    logic          fuse_s2_q;
    logic          wake_s1_q;
    logic          wake_s2_q;
    logic [PW-1:0] pin_s1_q;
    logic [PW-1:0] pin_s2_q;

    always_ff @(posedge mclk_i) begin
        fuse_s1_q <= fuse_i;
        fuse_s2_q <= fuse_s1_q;
        wake_s1_q <= wake_i;
        wake_s2_q <= wake_s1_q;
        pin_s1_q  <= pin_i;
        pin_s2_q  <= pin_s1_q;
    end

    // ------------------------------------------------------------
    // Compatibility fuse
    // ------------------------------------------------------------
    // Latched only in reset so decoding never moves under code
    logic legacy_compat_fuse_q;

    always_ff @(posedge mclk_i) begin
        if (srst_i)
            legacy_compat_fuse_q <= fuse_s2_q;
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            dsel_o     <= CMS_SEL_RAM;
            iosel_o    <= CMS_SEL_IO;
            xvec_o     <= 1'b0;
            wdt_seq_o  <= 1'b0;
            rx_dbl_o   <= 1'b0;
            pcint_en_o <= 1'b0;
            tmr2_en_o  <= 1'b0;
        end else begin
            dsel_o     <= decode(daddr_i, legacy_compat_fuse_q);
            // Short I/O ops map below the window by construction
            iosel_o    <= decode(`CMS_IO_BASE + {10'h000, ioaddr_i},
                                 legacy_compat_fuse_q);
            xvec_o     <= !legacy_compat_fuse_q;
            wdt_seq_o  <= !legacy_compat_fuse_q;
            rx_dbl_o   <= !legacy_compat_fuse_q;
            pcint_en_o <= !legacy_compat_fuse_q;
            tmr2_en_o  <= !legacy_compat_fuse_q;
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite slave
    // ------------------------------------------------------------
    logic [7:0]    aw_q;
    logic          aw_ok_q;
    logic [31:0]   wd_q;
    logic [3:0]    ws_q;
    logic          w_ok_q;
    logic [2:0]    ctrl_q;
    logic          se_q;
    logic [PW-1:0] dir_q;
    logic [PW-1:0] out_q;
    logic [PW-1:0] pud_q;
    logic          sleep_req;
    logic          hit;

    assign sleep_req = aw_ok_q && w_ok_q && !s_axi_bvalid
                    && aw_q == `CMS_OFS_SLEEP && ws_q[0] && wd_q[0];

    always_comb begin
        case (aw_q)
            `CMS_OFS_CTRL, `CMS_OFS_SLEEP, `CMS_OFS_DIR,
            `CMS_OFS_OUT, `CMS_OFS_BAUD0, `CMS_OFS_BAUD1,
            `CMS_OFS_PUD: hit = 1'b1;
            default:      hit = 1'b0;
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            aw_ok_q       <= 1'b0;
            w_ok_q        <= 1'b0;
            aw_q          <= 8'h00;
            wd_q          <= 32'h0000_0000;
            ws_q          <= 4'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `CMS_RESP_OK;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_q          <= s_axi_awaddr[7:0];
                aw_ok_q       <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wd_q         <= s_axi_wdata;
                ws_q         <= s_axi_wstrb;
                w_ok_q       <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (aw_ok_q && w_ok_q && !s_axi_bvalid) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= hit ? `CMS_RESP_OK : `CMS_RESP_ERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                aw_ok_q       <= 1'b0;
                w_ok_q        <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // Register stores; only byte lane 0 carries data
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            ctrl_q  <= `CMS_MD_IDLE;
            se_q    <= 1'b0;
            dir_q   <= '0;
            out_q   <= '0;
            pud_q   <= '0;
            baud0_o <= '0;
            baud1_o <= '0;
        end else if (aw_ok_q && w_ok_q && !s_axi_bvalid && ws_q[0]) begin
            case (aw_q)
                `CMS_OFS_CTRL: begin
                    ctrl_q <= wd_q[`CMS_CTRL_MODE];
                    se_q   <= wd_q[`CMS_CTRL_SE];
                end
                `CMS_OFS_DIR:   dir_q   <= wd_q[PW-1:0];
                `CMS_OFS_OUT:   out_q   <= wd_q[PW-1:0];
                `CMS_OFS_PUD:   pud_q   <= wd_q[PW-1:0];
                `CMS_OFS_BAUD0: baud0_o <= wd_q[BW-1:0];
                `CMS_OFS_BAUD1: baud1_o <= wd_q[BW-1:0];
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Sleep control
    // ------------------------------------------------------------
    cms_state_t st_q;
    cms_sleep_t md_q;

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            st_q <= CMS_ST_AWAKE;
            md_q <= CMS_SM_IDLE;
        end else begin
            case (st_q)
                CMS_ST_AWAKE:
                    if (sleep_req && se_q) begin
                        st_q <= CMS_ST_ASLEEP;
                        md_q <= mode_of(ctrl_q);
                    end
                CMS_ST_ASLEEP:
                    if (wake_s2_q)
                        st_q <= CMS_ST_AWAKE;
                default: st_q <= CMS_ST_AWAKE;
            endcase
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i || st_q == CMS_ST_AWAKE) begin
            cpu_run_o  <= 1'b1;
            io_run_o   <= 1'b1;
            osc_run_o  <= 1'b1;
            atmr_run_o <= 1'b1;
        end else begin
            cpu_run_o <= 1'b0;
            case (md_q)
                CMS_SM_IDLE: begin
                    io_run_o   <= 1'b1;
                    osc_run_o  <= 1'b1;
                    atmr_run_o <= 1'b1;
                end
                CMS_SM_PSAVE: begin
                    io_run_o   <= 1'b0;
                    osc_run_o  <= 1'b0;
                    atmr_run_o <= 1'b1;
                end
                CMS_SM_STBY: begin
                    io_run_o   <= 1'b0;
                    osc_run_o  <= 1'b1;
                    atmr_run_o <= 1'b0;
                end
                CMS_SM_XSTBY: begin
                    io_run_o   <= 1'b0;
                    osc_run_o  <= 1'b1;
                    atmr_run_o <= 1'b1;
                end
                default: begin
                    io_run_o   <= 1'b0;
                    osc_run_o  <= 1'b0;
                    atmr_run_o <= 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Read-while-write and register file
    // ------------------------------------------------------------
    // Only application-section fetches wait for the write to end
    always_ff @(posedge mclk_i) begin
        if (srst_i)
            stall_o <= 1'b0;
        else
            stall_o <= app_wr_i && !boot_fetch_i;
    end

    logic [7:0] rf_mem [32];

    always_ff @(posedge mclk_i) begin
        if (rf_we_i)
            rf_mem[rf_wa_i] <= rf_wd_i;
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            rf_a_o <= 8'h00;
            rf_b_o <= 8'h00;
        end else begin
            rf_a_o <= rf_mem[rf_ra_i];
            rf_b_o <= rf_mem[rf_rb_i];
        end
    end

    // ------------------------------------------------------------
    // Port pins
    // ------------------------------------------------------------
    // Reset is synchronous here, so release to high impedance takes
    // one edge; a clockless reset needs a pad-level gate outside.
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            pin_oe_n_o <= '1;
            pin_o      <= '0;
            pullup_o   <= '0;
        end else begin
            pin_oe_n_o <= ~dir_q;
            pin_o      <= out_q;
            pullup_o   <= ~dir_q & out_q & ~pud_q;
        end
    end

    // ------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `CMS_RESP_OK;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= `CMS_RESP_OK;
            s_axi_rdata   <= 32'h0000_0000;
            case (s_axi_araddr[7:0])
                `CMS_OFS_CTRL:  s_axi_rdata[3:0] <= {se_q, ctrl_q};
                `CMS_OFS_SLEEP: ;
                `CMS_OFS_STAT:  s_axi_rdata[4:0] <=
                    {md_q, st_q == CMS_ST_ASLEEP, legacy_compat_fuse_q};
                `CMS_OFS_DIR:   s_axi_rdata[PW-1:0] <= dir_q;
                `CMS_OFS_OUT:   s_axi_rdata[PW-1:0] <= out_q;
                `CMS_OFS_PIN:   s_axi_rdata[PW-1:0] <= pin_s2_q;
                `CMS_OFS_BAUD0: s_axi_rdata[BW-1:0] <= baud0_o;
                `CMS_OFS_BAUD1: s_axi_rdata[BW-1:0] <= baud1_o;
                `CMS_OFS_PUD:   s_axi_rdata[PW-1:0] <= pud_q;
                default:        s_axi_rresp <= `CMS_RESP_ERR;
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

endmodule
`default_nettype wire

// File: src/cms_defs.svh
// Constants for the compatibility-mode and sleep control block.
// Assumes inclusion by bare name from the package and the top module.
`ifndef CMS_DEFS_SVH
`define CMS_DEFS_SVH

// ----------------------------------------------------------------
// Data address space
// ----------------------------------------------------------------
`define CMS_IO_BASE    16'h0020
`define CMS_EXT_LO     16'h0060
`define CMS_EXT_HI     16'h00ff

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define CMS_OFS_CTRL   8'h00
`define CMS_OFS_SLEEP  8'h04
`define CMS_OFS_STAT   8'h08
`define CMS_OFS_DIR    8'h0c
`define CMS_OFS_OUT    8'h10
`define CMS_OFS_PIN    8'h14
`define CMS_OFS_BAUD0  8'h18
`define CMS_OFS_BAUD1  8'h1c
`define CMS_OFS_PUD    8'h20

// ----------------------------------------------------------------
// Fields and sleep-mode codes
// ----------------------------------------------------------------
`define CMS_CTRL_MODE  2:0
`define CMS_CTRL_SE    3
`define CMS_MD_IDLE    3'h0
`define CMS_MD_PDOWN   3'h2
`define CMS_MD_PSAVE   3'h3
`define CMS_MD_STBY    3'h6
`define CMS_MD_XSTBY   3'h7
`define CMS_RESP_OK    2'h0
`define CMS_RESP_ERR   2'h2

`endif

// File: src/cms_pkg.sv
// Types for the compatibility-mode and sleep control block.
// Assumes cms_defs.svh is on the include path.
package cms_pkg;
    `include "cms_defs.svh"

    typedef enum logic [2:0] {
        CMS_SM_IDLE, CMS_SM_PDOWN, CMS_SM_PSAVE,
        CMS_SM_STBY, CMS_SM_XSTBY
    } cms_sleep_t;

    typedef enum logic [1:0] {
        CMS_SEL_REGF, CMS_SEL_IO, CMS_SEL_EXT, CMS_SEL_RAM
    } cms_sel_t;

    typedef enum logic {
        CMS_ST_AWAKE, CMS_ST_ASLEEP
    } cms_state_t;
endpackage

// File: bench/cms_top_properties.sv
// Port-level checks bound into cms_top.
// Assumes reset is held several edges.
`timescale 1ns/10ps
`default_nettype none
module cms_top_properties
    import cms_pkg::*;
#(
    parameter int PW = 8                    // port width
) (
    input wire logic          mclk_i,       // clock
    input wire logic          srst_i,       // reset
    input wire logic [15:0]   daddr_i,      // data address
    input wire logic          wake_i,       // wake request
    input wire logic          boot_fetch_i, // boot fetch
    input wire logic [4:0]    rf_ra_i,      // read addr a
    input wire logic [4:0]    rf_rb_i,      // read addr b
    input wire logic [PW-1:0] pin_oe_n_o,   // drive enable
    input wire logic [PW-1:0] pullup_o,     // pull-up on
    input wire cms_sel_t      dsel_o,       // data decode
    input wire cms_sel_t      iosel_o,      // io decode
    input wire logic          xvec_o,       // ext vectors
    input wire logic          wdt_seq_o,    // timed sequence
    input wire logic          rx_dbl_o,     // double rx
    input wire logic          pcint_en_o,   // pin change
    input wire logic          tmr2_en_o,    // second timer
    input wire logic          cpu_run_o,    // cpu clock
    input wire logic          io_run_o,     // peripherals
    input wire logic          osc_run_o,    // oscillator
    input wire logic          atmr_run_o,   // async timer
    input wire logic          stall_o,      // fetch stall
    input wire logic [7:0]    rf_a_o,       // read data a
    input wire logic [7:0]    rf_b_o        // read data b
);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (srst_i);

    a_reset_tristate: assert property (disable iff (1'b0)
        srst_i |=> &pin_oe_n_o) else $error("pin driven");
    a_ext_window: assert property (
        !$past(srst_i) && daddr_i inside {[16'h0060:16'h00ff]}
        |=> dsel_o == (xvec_o ? CMS_SEL_EXT : CMS_SEL_RAM))
        else $error("ext decode");
    a_io_window: assert property (
        daddr_i inside {[16'h0020:16'h005f]}
        |=> dsel_o == CMS_SEL_IO && iosel_o == CMS_SEL_IO)
        else $error("io decode");
    a_feats_same: assert property (
        {wdt_seq_o, rx_dbl_o, pcint_en_o, tmr2_en_o} == {4{xvec_o}})
        else $error("features");
    a_fuse_frozen: assert property (
        !$past(srst_i) && !$past(srst_i, 2) |-> $stable(xvec_o))
        else $error("fuse moved");
    a_run_legal: assert property (
        {cpu_run_o, io_run_o, osc_run_o, atmr_run_o}
        inside {4'hf, 4'h7, 4'h0, 4'h1, 4'h2, 4'h3})
        else $error("run combo");
    a_wake_run: assert property (
        wake_i [*4] |-> ##[1:3] (cpu_run_o && osc_run_o))
        else $error("no wake");
    a_boot_runs: assert property (
        boot_fetch_i |=> !stall_o) else $error("boot stall");
    a_rf_dual: assert property (
        rf_ra_i == rf_rb_i |=> rf_a_o == rf_b_o)
        else $error("rf ports");
    a_pullup_input: assert property (
        (pullup_o & ~pin_oe_n_o) == '0) else $error("pullup out");
endmodule

bind cms_top cms_top_properties #(.PW(PW)) i_cms_top_properties (.*);
`default_nettype wire

// File: bench/cms_top_tb_top.sv
// Self-checking bench for cms_top.
// Assumes the checker file binds itself into the design.
`timescale 1ns/10ps
`default_nettype none
module cms_top_tb_top
    import cms_pkg::*;
;
    logic        mclk_i, srst_i, fuse_i, wake_i, boot_fetch_i, app_wr_i;
    logic        rf_we_i, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
    logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, xvec_o;
    logic        wdt_seq_o, rx_dbl_o, pcint_en_o, tmr2_en_o, cpu_run_o;
    logic        io_run_o, osc_run_o, atmr_run_o, stall_o, leg;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [3:0]  s_axi_wstrb;
    logic [4:0]  rf_ra_i, rf_rb_i, rf_wa_i;
    logic [5:0]  ioaddr_i;
    logic [7:0]  rf_wd_i, pin_i, pin_o, pin_oe_n_o, pullup_o, rf_a_o, rf_b_o;
    logic [7:0]  baud0_o, baud1_o, rfm [32];
    logic [15:0] daddr_i;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
    cms_sel_t    dsel_o, iosel_o;
    int          checked = 0, n_errors = 0;
    logic [3:0]  run;
    logic [4:0]  ft;
    logic [15:0] al [10] = '{16'h0000, 16'h001f, 16'h0020, 16'h005f,
        16'h0060, 16'h009b, 16'h00ff, 16'h0100, 16'hffff, 16'h0080};
    logic [2:0]  code [6] = '{3'h0, 3'h2, 3'h3, 3'h6, 3'h7, 3'h5};
    logic [2:0]  enc [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h0};
    logic [3:0]  runx [6] = '{4'h7, 4'h0, 4'h1, 4'h2, 4'h3, 4'h7};

    cms_top i_cms_top (.*);
    assign run = {cpu_run_o, io_run_o, osc_run_o, atmr_run_o};
    assign ft  = {xvec_o, wdt_seq_o, rx_dbl_o, pcint_en_o, tmr2_en_o};

    initial begin
        mclk_i = 1'b0;
        forever #5 mclk_i = ~mclk_i;
    end

    // ------------------------------------------------------------
    // Checking and bus tasks
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        checked++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic give_verdict();
        $display("checked %0d n_errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Only the watchdog ends a wait on a dead slave
    task automatic wr(input logic [31:0] a, d, input logic [1:0] er);
        @(posedge mclk_i);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge mclk_i);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        chk("bresp", er, s_axi_bresp);
    endtask

    task automatic rd(input logic [31:0] a, input logic [1:0] er,
                      output logic [31:0] d);
        @(posedge mclk_i);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge mclk_i);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        d = s_axi_rdata;
        chk("rresp", er, s_axi_rresp);
    endtask

    // ------------------------------------------------------------
    // Scenario tasks
    // ------------------------------------------------------------
    task automatic do_reset(input logic f);
        @(posedge mclk_i);
        srst_i <= 1'b1;
        fuse_i <= f;
        leg = f;
        repeat (12) @(posedge mclk_i);
        @(negedge mclk_i);
        chk("oe_n_rst", 8'hff, pin_oe_n_o);
        @(posedge mclk_i);
        srst_i <= 1'b0;
        repeat (3) @(posedge mclk_i);
        chk("feats", {5{~f}}, ft);
    endtask

    function automatic cms_sel_t exp_sel(input logic [15:0] a);
        if (a < 16'h0020) return CMS_SEL_REGF;
        if (a < 16'h0060) return CMS_SEL_IO;
        if (a < 16'h0100 && !leg) return CMS_SEL_EXT;
        return CMS_SEL_RAM;
    endfunction

    task automatic dec(input logic [15:0] a);
        @(posedge mclk_i);
        daddr_i <= a;
        ioaddr_i <= 6'($urandom);
        repeat (2) @(posedge mclk_i);
        chk("dsel", exp_sel(a), dsel_o);
        chk("iosel", CMS_SEL_IO, iosel_o);
    endtask

    task automatic dec_all();
        foreach (al[k]) dec(al[k]);
        repeat (8) dec(16'($urandom_range(0, 511)));
    endtask

    task automatic regs();
        logic [7:0]  b0, b1;
        logic [31:0] r;
        b0 = 8'($urandom);
        b1 = 8'($urandom);
        wr(32'h18, {24'h0, b0}, 2'h0);
        wr(32'h1c, {24'h0, b1}, 2'h0);
        rd(32'h1c, 2'h0, r);
        chk("baud1_rd", {24'h0, b1}, r);
        chk("baud0", b0, baud0_o);
        chk("baud1", b1, baud1_o);
        wr(32'h3c, 32'h5a, 2'h2);
        rd(32'h3c, 2'h2, r);
        rd(32'h08, 2'h0, r);
        chk("stat_fuse", leg, r[0]);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        logic [7:0]  d, o, p;
        logic [31:0] r;
        {srst_i, fuse_i, wake_i, boot_fetch_i, app_wr_i, rf_we_i} = 6'h20;
        {s_axi_arvalid, s_axi_rready, rf_ra_i, rf_rb_i, rf_wa_i} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, rf_wd_i, ioaddr_i} = '0;
        {s_axi_awaddr, s_axi_wdata, s_axi_araddr, daddr_i, pin_i} = '0;
        s_axi_wstrb = 4'hf;
        void'($urandom(50643));
        for (int i = 0; i < 32; i++) begin
            @(posedge mclk_i);
            rfm[i] = 8'($urandom);
            rf_we_i <= 1'b1;
            rf_wa_i <= 5'(i);
            rf_wd_i <= rfm[i];
        end
        @(posedge mclk_i);
        rf_we_i <= 1'b0;
        do_reset(1'b0);
        regs();
        dec_all();
        d = 8'($urandom);
        o = 8'($urandom);
        p = 8'($urandom);
        wr(32'h0c, {24'h0, d}, 2'h0);
        wr(32'h10, {24'h0, o}, 2'h0);
        wr(32'h20, {24'h0, p}, 2'h0);
        pin_i <= 8'($urandom);
        repeat (3) @(posedge mclk_i);
        chk("oe_n", {24'h0, ~d}, pin_oe_n_o);
        chk("pullup", {24'h0, ~d & o & ~p}, pullup_o);
        chk("pin_o", o & d, pin_o & d);
        rd(32'h14, 2'h0, r);
        chk("pin_rd", pin_i, r);
        do_reset(1'b0);
        app_wr_i <= 1'b1;
        boot_fetch_i <= 1'b1;
        repeat (2) @(posedge mclk_i);
        chk("stall_boot", 1'b0, stall_o);
        boot_fetch_i <= 1'b0;
        repeat (2) @(posedge mclk_i);
        chk("stall_app", 1'b1, stall_o);
        app_wr_i <= 1'b0;
        for (int i = 0; i < 20; i++) begin
            @(posedge mclk_i);
            d = 8'($urandom_range(0, 31));
            o = i[0] ? 8'($urandom_range(0, 31)) : d;
            rf_ra_i <= d[4:0];
            rf_rb_i <= o[4:0];
            repeat (2) @(posedge mclk_i);
            chk("rf_a", rfm[d], rf_a_o);
            chk("rf_b", rfm[o], rf_b_o);
        end
        // All mode codes plus one unused one
        for (int i = 0; i < 6; i++) begin
            wr(32'h00, {28'h0, 1'b1, code[i]}, 2'h0);
            wr(32'h04, 32'h1, 2'h0);
            repeat (2) @(posedge mclk_i);
            chk("run", runx[i], run);
            rd(32'h08, 2'h0, r);
            chk("stat", {27'h0, enc[i], 1'b1, leg}, r);
            @(posedge mclk_i);
            wake_i <= 1'b1;
            repeat (5) @(posedge mclk_i);
            wake_i <= 1'b0;
            @(posedge mclk_i);
            chk("run_wake", 4'hf, run);
        end
        do_reset(1'b1);
        regs();
        dec_all();
        fuse_i <= 1'b0;
        repeat (4) @(posedge mclk_i);
        chk("fuse_frozen", 5'h0, ft);
        dec(16'h0080);
        give_verdict();
    end

    initial begin
        repeat (50000) @(posedge mclk_i);
        n_errors++;
        give_verdict();
    end
endmodule
`default_nettype wire
